// *** design/tw_map.vh ***
/*
 * register map, field positions, reset values, status codes and bit-engine
 * command codes of the two-wire master-transmit controller.
 * assumes a 32-bit classic wishbone bus; every register is one aligned word.
 */
// Functional notes
// (R1) done flag set; bus stalled until cleared
// (R2) status code valid whenever done flag set
// (R3) master operation always starts with START
// (R4) address write bit selects transmit mode
// (R5) software requests START via control write
// (R6) START generated only once bus free
// (R7) after START: done flag, code 08
// (R8) writing one to done bit resumes
// (R9) software keeps enable bit set always
// (R10) software loads address, then clears done
// (R11) address sent: code 18, 20 or 38
// (R12) software writes data only while done
// (R13) data write while busy: collision, ignored
// (R14) software sends each byte same way
// (R15) stop request makes device send STOP
// (R16) start request while owning: repeated START
// (R17) after repeated START report code 10
// (R18) bus ownership kept across repeated START
// (R19) interrupt when done and irq enabled
`ifndef TW_MAP_VH
`define TW_MAP_VH
// word offsets (word index; byte address is offset times four)
`define TW_OFS_CTRL     6'h00
`define TW_OFS_STAT     6'h01
`define TW_OFS_DATA     6'h02
`define TW_OFS_RATE     6'h03
`define TW_OFS_IRQ_ST   6'h04
`define TW_OFS_IRQ_CLR  6'h05
`define TW_OFS_IRQ_EN   6'h06
`define TW_OFS_MODE     6'h07
// control register fields
`define TW_C_DONE       7
`define TW_C_ACKEN      6
`define TW_C_START      5
`define TW_C_STOP       4
`define TW_C_WCOL       3
`define TW_C_EN         2
`define TW_C_IRQEN      0
// irq status fields
`define TW_I_DONE       0
`define TW_I_WCOL       1
`define TW_I_ARB        2
`define TW_I_STOP       3
// reset values
`define TW_RST_CTRL     8'h00
`define TW_RST_RATE     8'h01
`define TW_RST_DATA     8'hFF
// status codes, prescaler bits zero
`define TW_SC_START     8'h08
`define TW_SC_RSTART    8'h10
`define TW_SC_AW_ACK    8'h18
`define TW_SC_AW_NACK   8'h20
`define TW_SC_D_ACK     8'h28
`define TW_SC_D_NACK    8'h30
`define TW_SC_ARB       8'h38
`define TW_SC_IDLE      8'hF8
// bit-engine commands
`define TW_CMD_START    3'h0
`define TW_CMD_STOP     3'h1
`define TW_CMD_WRITE    3'h2
`define TW_CMD_READ     3'h3
`define TW_CMD_REL      3'h4
// bits per byte before the acknowledge slot
`define TW_BITS_BYTE    4'h8
`endif

// *** design/tw_bit.v ***
/*
 * bit engine: plays one START, STOP, data bit or acknowledge slot on the
 * open-drain clock and data lines in four quarter periods.
 * assumes i_scl and i_sda already pass two flip-flops in the caller.
 */
`timescale 1ns/1ps
`include "tw_map.vh"
module tw_bit #(
	parameter QW = 16
) (
	input  wire          i_clk_sys,
	input  wire          i_srst,
	input  wire          i_go,
	input  wire [2:0]    i_cmd,
	input  wire          i_bit,
	input  wire [QW-1:0] i_quarter,
	input  wire          i_scl,
	input  wire          i_sda,
	output reg           o_done,
	output reg           o_bit,
	output reg           o_arb_lost,
	output reg           o_scl_oe,
	output reg           o_sda_oe
);
	reg          busy;      // a command in flight
	reg [1:0]    phase;     // quarter index
	reg [QW-1:0] cnt;       // cycles left in quarter
	reg [2:0]    cmd;       // command held
	reg          dbit;      // data bit held
	reg [1:0]    next_ph;   // phase to enter
	reg [2:0]    dcmd;      // command seen by the drive table
	reg          ddat;      // bit seen by the drive table
	reg          next_scl;  // clock drive on entry
	reg          next_sda;  // data drive on entry

	// drive table: line enables on entry to a phase
	always @* begin
		next_ph  = i_go ? 2'h0 : phase + 2'h1;
		dcmd     = i_go ? i_cmd : cmd;
		ddat     = i_go ? i_bit : dbit;
		next_scl = o_scl_oe;
		next_sda = o_sda_oe;
		case (dcmd)
			`TW_CMD_START: begin
				case (next_ph)
					2'h0: next_sda = 1'b0;
					2'h1: next_scl = 1'b0;
					2'h2: next_sda = 1'b1;
					default: next_scl = 1'b1;
				endcase
			end
			`TW_CMD_STOP: begin
				case (next_ph)
					2'h0: begin
						next_scl = 1'b1;
						next_sda = 1'b1;
					end
					2'h1: next_scl = 1'b0;
					2'h2: next_sda = 1'b0;
					default: next_sda = 1'b0;
				endcase
			end
			`TW_CMD_WRITE, `TW_CMD_READ: begin
				case (next_ph)
					2'h0: begin
						next_scl = 1'b1;
						next_sda = (dcmd == `TW_CMD_WRITE) ? ~ddat : 1'b0;
					end
					2'h1: next_scl = 1'b0;
					2'h2: next_scl = 1'b0;
					default: next_scl = 1'b1;
				endcase
			end
			default: begin
				next_scl = 1'b0;
				next_sda = 1'b0;
			end
		endcase
	end

	// quarter sequencer with clock-stretch wait and arbitration check
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			busy       <= 1'b0;
			phase      <= 2'h0;
			cnt        <= {QW{1'b0}};
			cmd        <= `TW_CMD_REL;
			dbit       <= 1'b1;
			o_done     <= 1'b0;
			o_bit      <= 1'b1;
			o_arb_lost <= 1'b0;
			o_scl_oe   <= 1'b0;
			o_sda_oe   <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_go) begin
				cmd        <= i_cmd;
				dbit       <= i_bit;
				phase      <= 2'h0;
				cnt        <= i_quarter - {{(QW-1){1'b0}}, 1'b1};
				busy       <= (i_cmd != `TW_CMD_REL);
				o_arb_lost <= 1'b0;
				o_scl_oe   <= next_scl;
				o_sda_oe   <= next_sda;
			end else if (busy) begin
				if (cnt != {QW{1'b0}}) begin
					cnt <= cnt - {{(QW-1){1'b0}}, 1'b1};
				end else if (phase == 2'h1 && !i_scl) begin
					cnt <= cnt;     // slave stretches the clock
				end else if (phase == 2'h3) begin
					busy   <= 1'b0;
					o_done <= 1'b1;
				end else begin
					if (phase == 2'h1) begin
						o_bit <= i_sda;
					end
					if (phase == 2'h1 && cmd == `TW_CMD_WRITE && dbit && !i_sda) begin
						busy       <= 1'b0;  // another master pulls data low
						o_done     <= 1'b1;
						o_arb_lost <= 1'b1;
						o_scl_oe   <= 1'b0;
						o_sda_oe   <= 1'b0;
					end else begin
						phase    <= next_ph;
						cnt      <= i_quarter - {{(QW-1){1'b0}}, 1'b1};
						o_scl_oe <= next_scl;
						o_sda_oe <= next_sda;
					end
				end
			end
		end
	end
endmodule // tw_bit

// *** design/tw_master.v ***
/*
 * two-wire master-transmit controller: wishbone register file, byte
 * sequencer, bus-free watch and interrupt logic around the bit engine.
 * assumes external pull-ups on clock and data; the pins are open-drain.
 */
`timescale 1ns/1ps
`include "tw_map.vh"
module tw_master #(
	parameter QW = 16
) (
	input  wire        i_clk_sys,
	input  wire        i_srst,
	input  wire        i_wb_cyc,
	input  wire        i_wb_stb,
	input  wire        i_wb_we,
	input  wire [7:0]  i_wb_adr,
	input  wire [3:0]  i_wb_sel,
	input  wire [31:0] i_wb_dat,
	output reg  [31:0] o_wb_dat,
	output reg         o_wb_ack,
	input  wire        i_scl,
	output reg         o_scl,
	output wire        o_scl_oe,
	input  wire        i_sda,
	output reg         o_sda,
	output wire        o_sda_oe,
	output reg         o_irq
);
	// sequencer states
	localparam S_IDLE  = 3'h0;  // nothing to do
	localparam S_FREE  = 3'h1;  // waiting for a free bus
	localparam S_START = 3'h2;  // start or repeated start in flight
	localparam S_BYTE  = 3'h3;  // byte and acknowledge in flight
	localparam S_STOP  = 3'h4;  // stop in flight
	localparam S_HOLD  = 3'h5;  // done flag set, bus stalled unless arbitration lost

	// synchronisers, two flip-flops each
	reg scl_m;      // first stage clock
	reg scl_s;      // second stage clock
	reg sda_m;      // first stage data
	reg sda_s;      // second stage data
	reg scl_p;      // previous clock sample
	reg sda_p;      // previous data sample
	reg bus_busy;   // start seen, stop not yet

	// software-visible state
	reg [7:0] ctrl;       // control register
	reg [7:0] code;       // status code, low bits zero
	reg [1:0] presc;      // prescaler bits
	reg [7:0] data;       // data register
	reg [7:0] rate;       // bit-rate register
	reg [3:0] irq_st;     // sticky events
	reg [3:0] irq_en;     // event enables
	reg       rx_mode;    // address carried the read bit
	reg       owned;      // this master holds the bus
	reg       kick;       // done bit written with enable

	// sequencer
	reg [2:0] state;      // current state
	reg [3:0] bitcnt;     // bits sent in this byte
	reg [7:0] sh;         // shift register
	reg       first;      // next byte is the address
	reg       rep;        // next start is a repeated one
	reg       go;         // pulse to the bit engine
	reg [2:0] cmd;        // command to the bit engine
	reg       dbit;       // bit to the bit engine

	wire          e_done;   // bit engine finished
	wire          e_bit;    // sampled data bit
	wire          e_arb;    // arbitration lost
	wire [QW-1:0] quarter;  // cycles per quarter period

	// bus access decode
	wire       wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	wire       wb_wr  = wb_req & i_wb_we & i_wb_sel[0];
	wire [5:0] widx   = i_wb_adr[7:2];
	wire [7:0] wd     = i_wb_dat[7:0];
	wire       en     = ctrl[`TW_C_EN];

	// quarter period length from rate and prescaler
	function [QW-1:0] quarter_of;
		input [7:0] r;
		input [1:0] p;
		reg   [QW-1:0] base;
		begin
			base       = {{(QW-8){1'b0}}, r} + {{(QW-1){1'b0}}, 1'b1};
			quarter_of = base << {p, 1'b0};
		end
	endfunction

	assign quarter = quarter_of(rate, presc);

	tw_bit #(
		.QW(QW)
	) u_bit (
		.i_clk_sys  (i_clk_sys),
		.i_srst     (i_srst),
		.i_go       (go),
		.i_cmd      (cmd),
		.i_bit      (dbit),
		.i_quarter  (quarter),
		.i_scl      (scl_s),
		.i_sda      (sda_s),
		.o_done     (e_done),
		.o_bit      (e_bit),
		.o_arb_lost (e_arb),
		.o_scl_oe   (o_scl_oe),
		.o_sda_oe   (o_sda_oe)
	);

	// pin synchronisers and bus-free watch
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			scl_m    <= 1'b1;
			scl_s    <= 1'b1;
			sda_m    <= 1'b1;
			sda_s    <= 1'b1;
			scl_p    <= 1'b1;
			sda_p    <= 1'b1;
			bus_busy <= 1'b0;
		end else begin
			scl_m <= i_scl;
			scl_s <= scl_m;
			sda_m <= i_sda;
			sda_s <= sda_m;
			scl_p <= scl_s;
			sda_p <= sda_s;
			if (scl_s && scl_p && sda_p && !sda_s) begin
				bus_busy <= 1'b1;  // start seen on the bus
			end else if (scl_s && scl_p && !sda_p && sda_s) begin
				bus_busy <= 1'b0;  // stop seen on the bus
			end
		end
	end

	// wishbone answer: one wait state, registered data
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else begin
			o_wb_ack <= wb_req;
			if (wb_req && !i_wb_we) begin
				case (widx)
					`TW_OFS_CTRL:   o_wb_dat <= {24'h00_0000, ctrl};
					`TW_OFS_STAT:   o_wb_dat <= {24'h00_0000, code[7:3], 1'b0, presc}; // [R2]
					`TW_OFS_DATA:   o_wb_dat <= {24'h00_0000, data};
					`TW_OFS_RATE:   o_wb_dat <= {24'h00_0000, rate};
					`TW_OFS_IRQ_ST: o_wb_dat <= {28'h000_0000, irq_st};
					`TW_OFS_IRQ_EN: o_wb_dat <= {28'h000_0000, irq_en};
					`TW_OFS_MODE:   o_wb_dat <= {29'h0000_0000, bus_busy, owned, rx_mode};
					default:        o_wb_dat <= 32'h0000_0000;
				endcase
			end
		end
	end

	// interrupt line: enabled events or done flag with irq enable
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= (|(irq_st & irq_en)) | (ctrl[`TW_C_DONE] & ctrl[`TW_C_IRQEN]); // [R19]
		end
	end

	// pin output levels: always low, the enables do the work
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_scl <= 1'b0;
			o_sda <= 1'b0;
		end else begin
			o_scl <= 1'b0;
			o_sda <= 1'b0;
		end
	end

	// registers and byte sequencer share one process for single drivers
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			ctrl    <= `TW_RST_CTRL;
			code    <= `TW_SC_IDLE;
			presc   <= 2'h0;
			data    <= `TW_RST_DATA;
			rate    <= `TW_RST_RATE;
			irq_st  <= 4'h0;
			irq_en  <= 4'h0;
			rx_mode <= 1'b0;
			owned   <= 1'b0;
			kick    <= 1'b0;
			state   <= S_IDLE;
			bitcnt  <= 4'h0;
			sh      <= 8'h00;
			first   <= 1'b0;
			rep     <= 1'b0;
			go      <= 1'b0;
			cmd     <= `TW_CMD_REL;
			dbit    <= 1'b1;
		end else begin
			go   <= 1'b0;
			kick <= 1'b0;

			// software writes
			if (wb_wr) begin
				case (widx)
					`TW_OFS_CTRL: begin
						ctrl[`TW_C_ACKEN] <= wd[`TW_C_ACKEN];
						ctrl[`TW_C_START] <= wd[`TW_C_START];
						ctrl[`TW_C_STOP]  <= wd[`TW_C_STOP];
						ctrl[`TW_C_EN]    <= wd[`TW_C_EN];
						ctrl[`TW_C_IRQEN] <= wd[`TW_C_IRQEN];
						if (wd[`TW_C_DONE]) begin
							ctrl[`TW_C_DONE] <= 1'b0;        // [R8]
							kick             <= wd[`TW_C_EN];
						end
					end
					`TW_OFS_STAT: presc <= wd[1:0];
					`TW_OFS_DATA: begin
						if (ctrl[`TW_C_DONE]) begin
							data             <= wd;
							ctrl[`TW_C_WCOL] <= 1'b0;
						end else begin
							ctrl[`TW_C_WCOL]    <= 1'b1;     // [R13]
							irq_st[`TW_I_WCOL] <= 1'b1;
						end
					end
					`TW_OFS_RATE:    rate   <= wd;
					`TW_OFS_IRQ_CLR: irq_st <= irq_st & ~wd[3:0];
					`TW_OFS_IRQ_EN:  irq_en <= wd[3:0];
					default: ;
				endcase
			end

			// sequencer; hardware sets below override a same-cycle clear
			if (!en) begin
				// disabled: drop the bus and forget the transfer
				if (state != S_IDLE || owned) begin
					go    <= 1'b1;
					cmd   <= `TW_CMD_REL;
					owned <= 1'b0;
				end
				state <= S_IDLE;
			end else begin
				case (state)
					S_IDLE, S_HOLD: begin
						if (kick) begin
							if (ctrl[`TW_C_STOP] && owned) begin
								go    <= 1'b1;               // [R15]
								cmd   <= `TW_CMD_STOP;
								state <= S_STOP;
							end else if (ctrl[`TW_C_START] && owned) begin
								go    <= 1'b1;               // [R16]
								cmd   <= `TW_CMD_START;
								rep   <= 1'b1;
								state <= S_START;
							end else if (ctrl[`TW_C_START]) begin
								rep   <= 1'b0;
								state <= S_FREE;             // [R6]
							end else if (owned) begin
								// first bit leaves here, once; later bits follow
								// each engine done pulse, so no bit is sent twice
								sh     <= data;              // [R4]
								bitcnt <= 4'h0;
								go     <= 1'b1;
								cmd    <= `TW_CMD_WRITE;
								dbit   <= data[7];
								state  <= S_BYTE;
								if (first) begin
									rx_mode <= data[0];
								end
							end else begin
								ctrl[`TW_C_STOP] <= 1'b0;
								state            <= S_IDLE;  // [R3]
							end
						end
					end
					S_FREE: begin
						// only a quiet bus may be taken
						if (!bus_busy && scl_s && sda_s) begin
							go    <= 1'b1;                   // [R6]
							cmd   <= `TW_CMD_START;
							state <= S_START;
						end
					end
					S_START: begin
						if (e_done) begin
							owned            <= 1'b1;        // [R18]
							first            <= 1'b1;
							ctrl[`TW_C_DONE] <= 1'b1;        // [R1]
							irq_st[`TW_I_DONE] <= 1'b1;
							code  <= rep ? `TW_SC_RSTART : `TW_SC_START; // [R7] [R17]
							state <= S_HOLD;
						end
					end
					S_BYTE: begin
						if (e_done && e_arb) begin
							owned              <= 1'b0;
							ctrl[`TW_C_DONE]   <= 1'b1;      // [R1]
							irq_st[`TW_I_DONE] <= 1'b1;
							irq_st[`TW_I_ARB]  <= 1'b1;
							code               <= `TW_SC_ARB; // [R11]
							state              <= S_HOLD;
						end else if (e_done && bitcnt == `TW_BITS_BYTE) begin
							ctrl[`TW_C_DONE]   <= 1'b1;      // [R1]
							irq_st[`TW_I_DONE] <= 1'b1;
							first              <= 1'b0;
							state              <= S_HOLD;
							if (first) begin
								code <= e_bit ? `TW_SC_AW_NACK : `TW_SC_AW_ACK; // [R11]
							end else begin
								code <= e_bit ? `TW_SC_D_NACK : `TW_SC_D_ACK;
							end
						end else if (e_done) begin
							// next bit, then the acknowledge slot
							// msb already left on entry; shift in step with done
							bitcnt <= bitcnt + 4'h1;
							go     <= 1'b1;
							if (bitcnt + 4'h1 == `TW_BITS_BYTE) begin
								cmd  <= `TW_CMD_READ;
								dbit <= 1'b1;
							end else begin
								cmd  <= `TW_CMD_WRITE;
								dbit <= sh[6];
								sh   <= {sh[6:0], 1'b0};
							end
						end
					end
					S_STOP: begin
						if (e_done) begin
							owned              <= 1'b0;
							ctrl[`TW_C_STOP]   <= 1'b0;      // [R15]
							irq_st[`TW_I_STOP] <= 1'b1;
							code               <= `TW_SC_IDLE;
							state <= ctrl[`TW_C_START] ? S_FREE : S_IDLE;
							rep   <= 1'b0;
						end
					end
					default: state <= S_IDLE;
				endcase
			end
		end
	end
endmodule // tw_master

// *** verif/tw_master_monitor.sv ***
/* checker for tw_master: wishbone handshake, line outputs, stretch.
   assumes it is bound to every tw_master instance. */
`timescale 1ns/1ps
module tw_master_monitor (
	input wire logic        i_clk_sys,
	input wire logic        i_srst,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        i_wb_we,
	input wire logic [7:0]  i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [31:0] o_wb_dat,
	input wire logic        o_wb_ack,
	input wire logic        i_scl,
	input wire logic        o_scl,
	input wire logic        o_scl_oe,
	input wire logic        o_sda,
	input wire logic        o_sda_oe,
	input wire logic        o_irq
);
	logic ds;                             // done flag as software last saw it
	wire  c0 = i_wb_adr[7:2] == 6'h00;    // control word addressed
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	// track done from control reads, drop it on a clearing write
	always @(posedge i_clk_sys) begin
		if (i_srst)
			ds <= 1'b0;
		else if (i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && c0 && i_wb_dat[7])
			ds <= 1'b0;
		else if (o_wb_ack && !i_wb_we && c0 && o_wb_dat[7])
			ds <= 1'b1;
	end
	a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack held past one cycle");
	a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb && !o_wb_ack))
		else $error("ack without request");
	a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("request not answered next cycle");
	a_rst_quiet: assert property ($fell(i_srst) |-> !o_wb_ack && !o_scl_oe && !o_sda_oe && !o_irq)
		else $error("outputs active after reset");
	a_open_drain: assert property (!o_scl && !o_sda)
		else $error("line output value not low");
	a_rd_upper: assert property (o_wb_ack && !i_wb_we |-> o_wb_dat[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_dat_hold: assert property (!o_wb_ack && !$fell(i_srst) |-> $stable(o_wb_dat))
		else $error("read data moved without ack");
	a_hold_stretch: assert property (ds |-> $stable(o_scl_oe) && $stable(o_sda_oe))
		else $error("lines moved while done set");
	a_start_free: assert property ($rose(o_sda_oe) && !o_scl_oe |-> i_scl)
		else $error("start driven while clock line low");
endmodule // tw_master_monitor

bind tw_master tw_master_monitor u_tw_master_monitor (
	.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
	.i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
	.o_wb_ack(o_wb_ack), .i_scl(i_scl), .o_scl(o_scl), .o_scl_oe(o_scl_oe),
	.o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_irq(o_irq));

// *** verif/tw_slave_model.sv ***
/* slave receiver model: shifts in bytes, acks on request, flags stop.
   assumes pulled-up lines; it only ever pulls data low. */
`timescale 1ns/1ps
module tw_slave_model (
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic       i_ack_en,
	output logic            o_sda_oe,
	output logic [7:0]      o_byte,
	output logic            o_stop
);
	int         nbit = -1;   // bit slot, -1 outside a frame
	logic [7:0] sh = 8'h00;  // shift register
	initial begin
		o_sda_oe = 1'b0;
		o_byte = 8'h00;
		o_stop = 1'b0;
	end
	// data falls with clock high: start or repeated start
	always @(negedge i_sda) if (i_scl) begin
		nbit = 0;
		o_stop = 1'b0;
	end
	// data rises with clock high: stop
	always @(posedge i_sda) if (i_scl) begin
		nbit = -1;
		o_stop = 1'b1;
	end
	// sample msb first on clock rise
	always @(posedge i_scl) if (nbit >= 0 && nbit < 8) begin
		sh = {sh[6:0], i_sda};
		nbit++;
	end
	// ack slot on ninth bit, then release the line
	always @(negedge i_scl) begin
		if (nbit == 8) begin
			o_sda_oe = i_ack_en;
			o_byte = sh;
			nbit = 9;
		end else if (nbit == 9) begin
			o_sda_oe = 1'b0;
			nbit = 0;
		end
	end
endmodule // tw_slave_model

// *** verif/tw_master_tb_top.sv ***
/* testbench: register reset table, start, address, data, repeated start,
   nack, stop and interrupts. assumes tw_slave_model on the lines. */
`timescale 1ns/1ps
`include "tw_map.vh"
module tw_master_tb_top;
	logic        clk = 1'b0;          // 10 MHz system clock
	logic        srst = 1'b1;         // synchronous reset
	logic        cyc = 1'b0;          // wishbone cycle
	logic        stb = 1'b0;          // wishbone strobe
	logic        we = 1'b0;           // write enable
	logic [7:0]  adr = 8'h00;         // byte address
	logic [31:0] wdat = 32'h0;        // write data
	logic        ack_en = 1'b1;       // slave acks when high
	logic [31:0] r;                   // last read data
	wire  [31:0] rdat;
	wire         ack, irq, scl_oe, sda_oe, s_oe, s_stop;
	wire  [7:0]  s_byte;
	wire         scl = !scl_oe;          // pulled-up clock line
	wire         sda = !(sda_oe || s_oe); // pulled-up data line
	int          num_errors = 0;
	int          samples_checked = 0;
	logic [13:0] rows [9] = '{{`TW_OFS_CTRL, `TW_RST_CTRL}, {`TW_OFS_STAT, `TW_SC_IDLE},
		{`TW_OFS_DATA, `TW_RST_DATA}, {`TW_OFS_RATE, `TW_RST_RATE}, {`TW_OFS_IRQ_ST, 8'h00},
		{`TW_OFS_IRQ_CLR, 8'h00}, {`TW_OFS_IRQ_EN, 8'h00}, {`TW_OFS_MODE, 8'h00},
		{6'h08, 8'h00}};
	logic [7:0]  bytes [2] = '{8'h5A, 8'hC3};
	always #50 clk = !clk;
	tw_master u_tw_master (.i_clk_sys(clk), .i_srst(srst), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .i_scl(scl), .o_scl(), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda(),
		.o_sda_oe(sda_oe), .o_irq(irq));
	tw_slave_model u_tw_slave_model (.i_scl(scl), .i_sda(sda), .i_ack_en(ack_en),
		.o_sda_oe(s_oe), .o_byte(s_byte), .o_stop(s_stop));
	// verdict and end of run
	task wrap_up;
		if (num_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// value compare
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one classic cycle, bounded wait for ack
	task wb(input logic w, input logic [5:0] i, input logic [7:0] v);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		wdat <= {24'h0, v};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			chk(ack, 1);
			wrap_up;
		end
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	// masked register read and compare
	task rd(input logic [5:0] i, input logic [7:0] m, input logic [7:0] e);
		wb(0, i, 8'h00);
		chk(r & {24'h0, m}, e);
	endtask
	// poll one control bit until it reads v
	task poll(input int b, input logic v);
		for (int n = 0; n < 400; n++) begin
			wb(0, `TW_OFS_CTRL, 8'h00);
			if (r[b] === v) break;
		end
		if (r[b] !== v) begin
			chk(r[b], v);
			wrap_up;
		end
	endtask
	// control write, optional colliding data write, wait done, check code
	task xfer(input logic [7:0] c, input logic [7:0] code, input logic cw);
		wb(1, `TW_OFS_CTRL, c);
		if (cw) wb(1, `TW_OFS_DATA, 8'h33);
		poll(`TW_C_DONE, 1'b1);
		rd(`TW_OFS_STAT, 8'hF8, code);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		foreach (rows[k]) rd(rows[k][13:8], 8'hFF, rows[k][7:0]);
		xfer(8'hA5, `TW_SC_START, 0);
		chk(irq, 1);
		chk(scl, 0);
		wb(1, `TW_OFS_DATA, 8'hA0);
		xfer(8'h85, `TW_SC_AW_ACK, 1);
		chk(s_byte, 8'hA0);
		rd(`TW_OFS_CTRL, 8'h08, 8'h08);
		foreach (bytes[k]) begin
			wb(1, `TW_OFS_DATA, bytes[k]);
			xfer(8'h85, `TW_SC_D_ACK, 0);
			chk(s_byte, bytes[k]);
		end
		xfer(8'hA5, `TW_SC_RSTART, 0);
		chk(s_stop, 0);
		rd(`TW_OFS_MODE, 8'h02, 8'h02);
		ack_en <= 1'b0;
		wb(1, `TW_OFS_DATA, 8'hB0);
		xfer(8'h85, `TW_SC_AW_NACK, 0);
		wb(1, `TW_OFS_CTRL, 8'h95);
		poll(`TW_C_STOP, 1'b0);
		rd(`TW_OFS_STAT, 8'hFF, `TW_SC_IDLE);
		chk(s_stop, 1);
		chk(irq, 0);
		wb(1, `TW_OFS_IRQ_EN, 8'h0A);
		repeat (2) @(posedge clk);
		chk(irq, 1);
		rd(`TW_OFS_IRQ_ST, 8'h0A, 8'h0A);
		wb(1, `TW_OFS_IRQ_CLR, 8'h0F);
		repeat (2) @(posedge clk);
		chk(irq, 0);
		rd(`TW_OFS_IRQ_ST, 8'h0F, 8'h00);
		wb(1, `TW_OFS_STAT, 8'h03);
		rd(`TW_OFS_STAT, 8'hFF, 8'hFB);
		rd(`TW_OFS_STAT, 8'hF8, `TW_SC_IDLE);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		rd(`TW_OFS_IRQ_EN, 8'hFF, 8'h00);
		wrap_up;
	end
endmodule // tw_master_tb_top
